//--- hdl/dual_pulse_length_dac.sv
// top of the dual pulse length dac: apb registers, timer base, two channels
// assumes an apb master on pclk and stop_mode driven by logic on pclk
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module dual_pulse_length_dac (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dual_pulse_length_dac_pkg::ADDR_W-1:0] paddr,
    input wire logic [dual_pulse_length_dac_pkg::DATA_W-1:0] pwdata,
    output logic [dual_pulse_length_dac_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    output logic pulse_length_a,
    output logic pulse_length_b
);
    localparam int DW = dual_pulse_length_dac_pkg::DUTY_W;
    localparam int CW = dual_pulse_length_dac_pkg::COUNT_W;
    localparam int NCH = dual_pulse_length_dac_pkg::CHANNELS;

    // software visible state
    logic [DW-1:0] pulse_length_a_value;
    logic [DW-1:0] pulse_length_b_value;
    logic rate_select_a;
    logic rate_select_b;
    logic timer_restart;

    // timer and channel state
    logic tick;
    logic [CW-1:0] count;
    logic [DW-1:0] shadow [NCH];
    logic rate_slow [NCH];
    logic [DW-1:0] active [NCH];
    logic out_bit [NCH];

    // bus decode
    logic setup_phase;
    logic wr_en;
    logic [5:0] wr_idx;

    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign wr_idx = paddr[7:2];

    // read data for a register index
    function automatic logic [31:0] read_word(input logic [5:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (idx)
            dual_pulse_length_dac_pkg::IDX_DUTY_A: begin
                w[DW-1:0] = pulse_length_a_value;
            end
            dual_pulse_length_dac_pkg::IDX_DUTY_B: begin
                w[DW-1:0] = pulse_length_b_value;
            end
            dual_pulse_length_dac_pkg::IDX_MISC: begin
                w[dual_pulse_length_dac_pkg::MISC_RATE_A_BIT] = rate_select_a;
                w[dual_pulse_length_dac_pkg::MISC_RATE_B_BIT] = rate_select_b;
            end
            dual_pulse_length_dac_pkg::IDX_STATUS: begin
                w[dual_pulse_length_dac_pkg::STAT_ACTIVE_A_LSB +: DW] = active[0];
                w[dual_pulse_length_dac_pkg::STAT_ACTIVE_B_LSB +: DW] = active[1];
                w[dual_pulse_length_dac_pkg::STAT_OUT_A_BIT] = out_bit[0];
                w[dual_pulse_length_dac_pkg::STAT_OUT_B_BIT] = out_bit[1];
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        read_word = w;
    endfunction

    // answer one cycle after setup, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !dual_pulse_length_dac_pkg::addr_mapped(paddr);
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= (!pwrite && dual_pulse_length_dac_pkg::addr_mapped(paddr)) ? read_word(wr_idx)
                                                                                  : 32'h0000_0000;
        end
    end

    // duty registers, written at any time, used at next period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_length_a_value <= dual_pulse_length_dac_pkg::DUTY_RESET;
            pulse_length_b_value <= dual_pulse_length_dac_pkg::DUTY_RESET;
        end else if (wr_en) begin
            if (wr_idx == dual_pulse_length_dac_pkg::IDX_DUTY_A) begin
                pulse_length_a_value <= pwdata[DW-1:0];
            end
            if (wr_idx == dual_pulse_length_dac_pkg::IDX_DUTY_B) begin
                pulse_length_b_value <= pwdata[DW-1:0];
            end
        end
    end

    // rate selects act at once, unbuffered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_select_a <= dual_pulse_length_dac_pkg::RATE_RESET;
            rate_select_b <= dual_pulse_length_dac_pkg::RATE_RESET;
        end else if (wr_en && wr_idx == dual_pulse_length_dac_pkg::IDX_MISC) begin
            rate_select_a <= pwdata[dual_pulse_length_dac_pkg::MISC_RATE_A_BIT];
            rate_select_b <= pwdata[dual_pulse_length_dac_pkg::MISC_RATE_B_BIT];
        end
    end

    // one cycle timer counter restart on write of one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_restart <= 1'b0;
        end else begin
            timer_restart <= wr_en && (wr_idx == dual_pulse_length_dac_pkg::IDX_TIMER_CTRL)
                             && pwdata[dual_pulse_length_dac_pkg::TCTRL_RESTART_BIT];
        end
    end

    // shared timer; only stop freezes it, processor wait does not
    timer_base u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .halt(stop_mode),
        .restart(timer_restart),
        .tick(tick),
        .count(count)
    );

    // per channel settings, mode changes take effect mid period
    assign shadow[0] = pulse_length_a_value;
    assign shadow[1] = pulse_length_b_value;
    assign rate_slow[0] = rate_select_a;
    assign rate_slow[1] = rate_select_b;

    // two identical channels
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chan
            pulse_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick),
                .count(count),
                .rate_slow(rate_slow[gi]),
                .shadow(shadow[gi]),
                .pulse_out(out_bit[gi]),
                .active(active[gi])
            );
        end
    endgenerate

    // pins straight from the channel flops
    assign pulse_length_a = out_bit[0];
    assign pulse_length_b = out_bit[1];

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // timer clock is one in four cpu clocks
    a_tick_spacing: assert property (tick |=> !tick [*3])
        else $error("timer tick closer than four clocks");

    // counter restart clears the count
    a_restart_count: assert property (timer_restart |=> count == 12'h000)
        else $error("timer counter not cleared by restart");

    // stop freezes both outputs
    a_stop_hold: assert property (stop_mode |=> $stable(pulse_length_a) && $stable(pulse_length_b))
        else $error("output moved during stop");

    // rate select a follows misc bit 3
    a_rate_a_write: assert property (wr_en && wr_idx == dual_pulse_length_dac_pkg::IDX_MISC
        |=> rate_select_a == $past(pwdata[dual_pulse_length_dac_pkg::MISC_RATE_A_BIT]))
        else $error("rate select a not written");

    // rate select b follows its misc bit
    a_rate_b_write: assert property (wr_en && wr_idx == dual_pulse_length_dac_pkg::IDX_MISC
        |=> rate_select_b == $past(pwdata[dual_pulse_length_dac_pkg::MISC_RATE_B_BIT]))
        else $error("rate select b not written");

    // answer comes one cycle after setup and lasts one cycle
    a_bus_answer: assert property (setup_phase |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // per channel waveform checks
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chk
            logic [DW-1:0] ph;
            logic st;
            assign ph = dual_pulse_length_dac_pkg::phase_of(count, rate_slow[gi]);
            assign st = dual_pulse_length_dac_pkg::is_start(count, rate_slow[gi]);

            a_zero_low: assert property (out_bit[gi] |-> active[gi] != 8'h00)
                else $error("output high with zero duty");

            a_half_fall: assert property (tick && !st && active[gi] == 8'h80 && ph == 8'h80
                |=> !out_bit[gi])
                else $error("half duty not low at mid period");

            a_full_high: assert property (tick && !st && active[gi] == 8'hFF && ph == 8'hFE
                |=> out_bit[gi])
                else $error("full duty not high before last step");

            a_update_edge: assert property (!$stable(active[gi]) |-> $past(tick && st))
                else $error("duty buffer changed mid period");

            // a rate change may re-phase a running period, so rises right after one are exempt
            a_rise_start: assert property ($rose(out_bit[gi]) && rate_slow[gi] == $past(rate_slow[gi], 4)
                |-> $past(tick && st))
                else $error("output rose away from period start");

            a_slow_no_reload: assert property (tick && rate_slow[gi] && count[7:0] == 8'h00
                && count != 12'h000 |=> $stable(active[gi]))
                else $error("slow channel reloaded at 256");

            a_fast_reload: assert property (tick && !rate_slow[gi] && count[7:0] == 8'h00
                && !timer_restart |=> active[gi] == $past(shadow[gi]))
                else $error("fast channel missed reload at 256");

            c_slow_period: cover property (tick && rate_slow[gi] && st ##1 out_bit[gi]);
            c_fast_period: cover property (tick && !rate_slow[gi] && st ##1 out_bit[gi]);
        end
    endgenerate

    c_stop_entry: cover property (pulse_length_a && stop_mode ##1 stop_mode);
    c_duty_write: cover property (wr_en && wr_idx == dual_pulse_length_dac_pkg::IDX_DUTY_A);

endmodule

//--- hdl/dual_pulse_length_dac_pkg.sv
// constants, register map and shared decode for the dual pulse length dac
// assumes one clock pclk acting as the cpu clock, apb register access
//
// Behaviour
// - two independent 8-bit channels, each with own duty register and output pin
// - slow mode repetition period is 4096 timer clock periods
// - fast mode repetition period is 256 timer clock periods
// - timer clock period equals four cpu clock periods
// - duty zero keeps the output low for the whole period
// - duty 80 hex gives half-period high time
// - duty ff gives 255/256 high; high time scales as duty over 256
// - duty writes take effect only at the end of a complete period
// - restarting the shared timer counter disturbs both outputs
// - both duty registers reset to zero
// - processor wait state leaves the waveforms untouched
// - rate select a, misc bit 3: set slow 4096, clear fast 256
// - rate select b: set slow 4096, clear fast 256
// - in stop mode outputs hold level, resume afterwards
package dual_pulse_length_dac_pkg;

    // widths and timing
    localparam int DUTY_W = 8;
    localparam int COUNT_W = 12;
    localparam int CHANNELS = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TIMER_DIV = 4;
    localparam int FAST_PERIOD = 256;
    localparam int SLOW_PERIOD = 4096;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DUTY_A = 6'h0A;
    localparam logic [5:0] IDX_DUTY_B = 6'h0B;
    localparam logic [5:0] IDX_MISC = 6'h0C;
    localparam logic [5:0] IDX_TIMER_CTRL = 6'h0D;
    localparam logic [5:0] IDX_STATUS = 6'h0E;

    // field positions
    localparam int MISC_RATE_A_BIT = 3;
    localparam int MISC_RATE_B_BIT = 2;
    localparam int TCTRL_RESTART_BIT = 0;
    localparam int STAT_ACTIVE_A_LSB = 0;
    localparam int STAT_ACTIVE_B_LSB = 8;
    localparam int STAT_OUT_A_BIT = 16;
    localparam int STAT_OUT_B_BIT = 17;

    // reset values
    localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
    localparam logic RATE_RESET = 1'b0;

    // position within the period, one step per 256th of it
    function automatic logic [DUTY_W-1:0] phase_of(input logic [COUNT_W-1:0] c, input logic slow);
        phase_of = slow ? c[COUNT_W-1 -: DUTY_W] : c[DUTY_W-1:0];
    endfunction

    // first timer tick of a period
    function automatic logic is_start(input logic [COUNT_W-1:0] c, input logic slow);
        is_start = slow ? (c == 12'h000) : (c[DUTY_W-1:0] == 8'h00);
    endfunction

    // word-aligned address that hits a register
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a[1:0] == 2'h0) && (a[7:2] >= IDX_DUTY_A) && (a[7:2] <= IDX_STATUS);
    endfunction

endpackage

//--- hdl/pulse_channel.sv
// one pulse length channel with its double buffered duty value
// assumes tick and count from the shared timer base
`timescale 1ns/100ps
module pulse_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic [dual_pulse_length_dac_pkg::COUNT_W-1:0] count,
    input wire logic rate_slow,
    input wire logic [dual_pulse_length_dac_pkg::DUTY_W-1:0] shadow,
    output logic pulse_out,
    output logic [dual_pulse_length_dac_pkg::DUTY_W-1:0] active
);
    logic [dual_pulse_length_dac_pkg::DUTY_W-1:0] phase;
    logic start;
    logic [dual_pulse_length_dac_pkg::DUTY_W-1:0] duty_eff;

    // period position and the duty value that governs it
    always_comb begin
        phase = dual_pulse_length_dac_pkg::phase_of(count, rate_slow);
        start = dual_pulse_length_dac_pkg::is_start(count, rate_slow);
        duty_eff = start ? shadow : active;
    end

    // buffered duty picked up only at a period boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= dual_pulse_length_dac_pkg::DUTY_RESET;
        end else if (tick && start) begin
            active <= shadow;
        end
    end

    // high from period start until phase reaches duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_out <= 1'b0;
        end else if (tick) begin
            pulse_out <= (phase < duty_eff);
        end
    end
endmodule

//--- hdl/timer_base.sv
// shared prescaler and free running timer counter for both channels
// assumes halt and restart come from logic on pclk
`timescale 1ns/100ps
module timer_base (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic halt,
    input wire logic restart,
    output logic tick,
    output logic [dual_pulse_length_dac_pkg::COUNT_W-1:0] count
);
    localparam logic [1:0] DIV_MAX = 2'(dual_pulse_length_dac_pkg::TIMER_DIV - 1);

    logic [1:0] prescale;

    // one timer clock every four cpu clocks, frozen while halted
    assign tick = (prescale == DIV_MAX) && !halt && !restart;

    // prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 2'h0;
        end else if (restart) begin
            prescale <= 2'h0;
        end else if (!halt) begin
            prescale <= (prescale == DIV_MAX) ? 2'h0 : prescale + 2'h1;
        end
    end

    // timer counter, cleared by a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 12'h000;
        end else if (restart) begin
            count <= 12'h000;
        end else if (tick) begin
            count <= count + 12'h001;
        end
    end
endmodule

//--- verif/dual_pulse_length_dac_tb.sv
// self-checking bench: apb register table, then waveform, buffer, restart, stop
// assumes one load model per output pin, 100 MHz pclk
`timescale 1ns/100ps
module dual_pulse_length_dac_tb;
    localparam logic [7:0] ADDR_A = {dual_pulse_length_dac_pkg::IDX_DUTY_A, 2'h0};
    localparam logic [7:0] ADDR_B = {dual_pulse_length_dac_pkg::IDX_DUTY_B, 2'h0};
    localparam logic [7:0] ADDR_MISC = {dual_pulse_length_dac_pkg::IDX_MISC, 2'h0};
    localparam logic [7:0] ADDR_TCTRL = {dual_pulse_length_dac_pkg::IDX_TIMER_CTRL, 2'h0};
    localparam logic [7:0] ADDR_STAT = {dual_pulse_length_dac_pkg::IDX_STATUS, 2'h0};
    localparam int DIV = dual_pulse_length_dac_pkg::TIMER_DIV;
    localparam int FAST = dual_pulse_length_dac_pkg::FAST_PERIOD * DIV;
    localparam int SLOW = dual_pulse_length_dac_pkg::SLOW_PERIOD * DIV;
    typedef struct {logic wr; logic [7:0] addr; logic [31:0] data; logic [31:0] exp; logic err;} row_t;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stop_mode = 1'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pulse_length_a, pulse_length_b;
    logic [15:0] period_a, high_a, rises_a, period_b, high_b, rises_b;
    logic [31:0] rd;
    logic err, seen, lvl_a, lvl_b;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    row_t rows [11];
    always #5 pclk = ~pclk;
    dual_pulse_length_dac dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .pulse_length_a(pulse_length_a), .pulse_length_b(pulse_length_b));
    pulse_load_model load_a (.pclk(pclk), .presetn(presetn), .level(pulse_length_a), .period(period_a),
        .high_time(high_a), .rises(rises_a));
    pulse_load_model load_b (.pclk(pclk), .presetn(presetn), .level(pulse_length_b), .period(period_b),
        .high_time(high_b), .rises(rises_b));
    // verdict and end of run
    task wrap_up();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            wrap_up();
        end
    end
    task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task chk_time(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // one apb transfer; answer taken at the rising edge that sees pready, request released there
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1);
        chk_bit("one access cycle", 1'h1, n == 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // wait for n more rises on one output, bounded
    task wait_rises(input logic ch, input logic [15:0] n);
        logic [15:0] s;
        int k;
        s = ch ? rises_b : rises_a;
        k = 0;
        while (16'((ch ? rises_b : rises_a) - s) < n && k < 60000) begin
            k++;
            @(negedge pclk);
        end
        chk_bit("rise seen", 1'h1, k < 60000);
    endtask
    initial begin
        rows[0] = '{1'h0, ADDR_A, 32'h0, 32'h0, 1'h0};
        rows[1] = '{1'h0, ADDR_B, 32'h0, 32'h0, 1'h0};
        rows[2] = '{1'h0, ADDR_MISC, 32'h0, 32'h0, 1'h0};
        rows[3] = '{1'h1, ADDR_A, 32'h80, 32'h0, 1'h0};
        rows[4] = '{1'h1, ADDR_B, 32'hFF, 32'h0, 1'h0};
        rows[5] = '{1'h0, ADDR_A, 32'h0, 32'h80, 1'h0};
        rows[6] = '{1'h0, ADDR_B, 32'h0, 32'hFF, 1'h0};
        rows[7] = '{1'h0, 8'h3C, 32'h0, 32'h0, 1'h1};
        rows[8] = '{1'h1, 8'h29, 32'h11, 32'h0, 1'h1};
        rows[9] = '{1'h1, ADDR_STAT, 32'hFFFFFFFF, 32'h0, 1'h0};
        rows[10] = '{1'h0, ADDR_A, 32'h0, 32'h80, 1'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        // zero duty keeps both pins low
        seen = 1'h0;
        repeat (1100) begin
            @(negedge pclk);
            seen = seen | pulse_length_a | pulse_length_b;
        end
        chk_bit("idle low", 1'h0, seen);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            chk_bit("pslverr", rows[i].err, err);
            if (!rows[i].wr) chk_word("prdata", rows[i].exp, rd);
        end
        // fast mode waveforms
        wait_rises(1'h0, 16'h0003);
        chk_time("period a", 16'(FAST), period_a);
        chk_time("high a", 16'(8'h80 * DIV), high_a);
        chk_time("period b", 16'(FAST), period_b);
        chk_time("high b", 16'(8'hFF * DIV), high_b);
        // new duty waits for the period end
        apb(1'h1, ADDR_A, 32'h20);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk_word("active a", 32'h80, {24'h0, rd[7:0]});
        wait_rises(1'h0, 16'h0002);
        chk_time("high a new", 16'(8'h20 * DIV), high_a);
        apb(1'h0, ADDR_STAT, 32'h0);
        chk_word("active a new", 32'h20, {24'h0, rd[7:0]});
        // counter restart in the low phase starts a new period
        repeat (300) @(posedge pclk);
        chk_bit("a low", 1'h0, pulse_length_a);
        apb(1'h1, ADDR_TCTRL, 32'h1);
        repeat (16) begin
            @(negedge pclk);
            if (pulse_length_a === 1'h1) break;
        end
        chk_bit("a after restart", 1'h1, pulse_length_a);
        // stop freezes both levels, then operation resumes
        repeat (20) @(posedge pclk);
        stop_mode <= 1'h1;
        @(negedge pclk);
        lvl_a = pulse_length_a;
        lvl_b = pulse_length_b;
        seen = 1'h1;
        repeat (600) begin
            @(negedge pclk);
            seen = seen & (pulse_length_a === lvl_a) & (pulse_length_b === lvl_b);
        end
        chk_bit("stop hold", 1'h1, seen);
        @(posedge pclk);
        stop_mode <= 1'h0;
        wait_rises(1'h0, 16'h0002);
        chk_time("period a resumed", 16'(FAST), period_a);
        // slow mode: rates first, then duties
        apb(1'h1, ADDR_MISC, 32'h0C);
        apb(1'h0, ADDR_MISC, 32'h0);
        chk_word("misc", 32'h0C, rd);
        apb(1'h1, ADDR_A, 32'h40);
        apb(1'h1, ADDR_B, 32'h01);
        wait_rises(1'h1, 16'h0003);
        chk_time("slow period a", 16'(SLOW), period_a);
        chk_time("slow high a", 16'(8'h40 * SLOW / 256), high_a);
        chk_time("slow period b", 16'(SLOW), period_b);
        chk_time("slow high b", 16'(SLOW / 256), high_b);
        // reset in mid run clears both duty registers and the pins
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        chk_bit("pins in reset", 1'h0, pulse_length_a | pulse_length_b);
        presetn <= 1'h1;
        apb(1'h0, ADDR_A, 32'h0);
        chk_word("duty a after reset", 32'h0, rd);
        apb(1'h0, ADDR_B, 32'h0);
        chk_word("duty b after reset", 32'h0, rd);
        wrap_up();
    end
endmodule

//--- verif/pulse_load_model.sv
// load model on one pulse output: measures period, high time and rises
// assumes the pulse level is registered on pclk
`timescale 1ns/100ps
module pulse_load_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic [15:0] period,
    output logic [15:0] high_time,
    output logic [15:0] rises
);
    logic prev;
    logic [15:0] run;
    logic [15:0] hi;
    // one sample per pclk; a rise closes the previous period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'h0;
            run <= 16'h0000;
            hi <= 16'h0000;
            period <= 16'h0000;
            high_time <= 16'h0000;
            rises <= 16'h0000;
        end else begin
            prev <= level;
            if (level && !prev) begin
                period <= run;
                high_time <= hi;
                rises <= rises + 16'h0001;
                run <= 16'h0001;
                hi <= 16'h0001;
            end else begin
                run <= run + 16'h0001;
                if (level) begin
                    hi <= hi + 16'h0001;
                end
            end
        end
    end
endmodule
